// ---- rtl/ieb_top.sv ----
// Interrupt enable bank with its AHB-Lite register slave.
//
// Overview of operation
// RULE1 - An enable bit at one passes its source's request; zero blocks it.
// RULE2 - Unimplemented bit positions read as zero and ignore writes.
// RULE3 - Every implemented enable bit is read/write and clears at reset.
// RULE4 - Software must route an enabled external pin source to a pin.
// RULE5 - Bank 0 holds thirteen enables at bits 13 to 5 and 3 to 0.
// RULE6 - Bank 1 holds fourteen enables, leaving bits 8 and 5 empty.
// RULE7 - Bank 2 holds enables at bits 13 to 5, 1 and 0.
// RULE8 - Bank 3 holds enables at bits 14, 6, 5, 2 and 1.
// RULE9 - Each source has a flag that hardware sets and software may write.
// RULE10 - Each source has a three-bit priority where zero disables it.
// RULE11 - A request is presented only with flag, enable and priority set.
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module ieb_top
	import ieb_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic [63:0] src_req,
	output logic      [63:0] src_irq_req,
	output logic      [2:0]  top_level,
	output logic             irq
);

	// ==================================================================
	// Declarations
	logic        addr_phase;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [7:0]  addr_q;
	logic        wr_commit;
	logic        status_clr;
	logic [15:0] rd_word;
	logic [3:0]  status_q;
	logic [3:0]  status_d;
	logic [3:0]  mask_q;
	logic [3:0]  mask_d;
	logic [3:0]  new_req;
	logic [3:0]  enable_we;
	logic [3:0]  flag_we;
	logic [3:0]  prio_we   [NUM_BANKS];
	logic [15:0] enable_q  [NUM_BANKS];
	logic [15:0] flag_q    [NUM_BANKS];
	logic [47:0] prio_q    [NUM_BANKS];
	logic [15:0] req_q     [NUM_BANKS];
	logic [2:0]  level_d;
	logic        hready_q;
	logic [31:0] hrdata_q;
	logic        irq_q;
	logic [2:0]  level_q;

	// ==================================================================
	// Bus address phase capture
	// Only whole-word single transfers are expected, so hsize and the
	// low address bits are not used to pick lanes.
	assign addr_phase = hsel & htrans[1] & hready;
	assign wr_commit  = wr_pend_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= addr_phase & hwrite;
			rd_pend_q <= addr_phase & ~hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
		end else if (addr_phase) begin
			addr_q <= haddr[7:0];
		end
	end

	// ==================================================================
	// Ready and read data
	// Reads take one wait state so that a write committed in the
	// preceding data phase is already visible in the returned word.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_q <= 1'b1;
		end else if (addr_phase & ~hwrite) begin
			hready_q <= 1'b0;
		end else if (rd_pend_q) begin
			hready_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_pend_q) begin
			hrdata_q <= {16'h0000, rd_word};
		end
	end

	always_comb begin
		rd_word = 16'h0000;
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (addr_q == 8'(OFF_ENABLE_BASE + WORD_BYTES * b)) begin
				rd_word = enable_q[b]; // RULE3
			end
			if (addr_q == 8'(OFF_FLAG_BASE + WORD_BYTES * b)) begin
				rd_word = flag_q[b]; // RULE9
			end
			for (int w = 0; w < PRIO_WORDS; w++) begin
				if (addr_q == 8'(OFF_PRIO_BASE + PRIO_BANK_BYTES * b
						+ WORD_BYTES * w)) begin
					for (int f = 0; f < FIELDS_WORD; f++) begin
						rd_word[f*FIELD_STRIDE +: PRIO_W] =
							prio_q[b][(w*FIELDS_WORD+f)*PRIO_W +: PRIO_W];
					end
				end
			end
		end
		if (addr_q == OFF_STATUS) begin
			rd_word = {12'h000, status_q};
		end
		if (addr_q == OFF_MASK) begin
			rd_word = {12'h000, mask_q};
		end
	end

	// ==================================================================
	// Write strobes
	always_comb begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			enable_we[b] = wr_commit
				&& (addr_q == 8'(OFF_ENABLE_BASE + WORD_BYTES * b));
			flag_we[b]   = wr_commit
				&& (addr_q == 8'(OFF_FLAG_BASE + WORD_BYTES * b));
			for (int w = 0; w < PRIO_WORDS; w++) begin
				prio_we[b][w] = wr_commit
					&& (addr_q == 8'(OFF_PRIO_BASE + PRIO_BANK_BYTES * b
						+ WORD_BYTES * w));
			end
		end
	end

	// ==================================================================
	// Source banks
	// External pin sources only see events once software has routed
	// them to a remappable pin; this block cannot tell if that was done.
	// RULE4
	ieb_bank #(
		.IMPL      (BANK0_IMPL) // RULE5
	) bank0_inst (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable_we (enable_we[0]),
		.flag_we   (flag_we[0]),
		.prio_we   (prio_we[0]),
		.wdata     (hwdata[15:0]),
		.src_req   (src_req[15:0]),
		.enable_q  (enable_q[0]),
		.flag_q    (flag_q[0]),
		.prio_q    (prio_q[0]),
		.req_q     (req_q[0]),
		.new_req   (new_req[0])
	);

	ieb_bank #(
		.IMPL      (BANK1_IMPL) // RULE6
	) bank1_inst (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable_we (enable_we[1]),
		.flag_we   (flag_we[1]),
		.prio_we   (prio_we[1]),
		.wdata     (hwdata[15:0]),
		.src_req   (src_req[31:16]),
		.enable_q  (enable_q[1]),
		.flag_q    (flag_q[1]),
		.prio_q    (prio_q[1]),
		.req_q     (req_q[1]),
		.new_req   (new_req[1])
	);

	ieb_bank #(
		.IMPL      (BANK2_IMPL) // RULE7
	) bank2_inst (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable_we (enable_we[2]),
		.flag_we   (flag_we[2]),
		.prio_we   (prio_we[2]),
		.wdata     (hwdata[15:0]),
		.src_req   (src_req[47:32]),
		.enable_q  (enable_q[2]),
		.flag_q    (flag_q[2]),
		.prio_q    (prio_q[2]),
		.req_q     (req_q[2]),
		.new_req   (new_req[2])
	);

	ieb_bank #(
		.IMPL      (BANK3_IMPL) // RULE8
	) bank3_inst (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable_we (enable_we[3]),
		.flag_we   (flag_we[3]),
		.prio_we   (prio_we[3]),
		.wdata     (hwdata[15:0]),
		.src_req   (src_req[63:48]),
		.enable_q  (enable_q[3]),
		.flag_q    (flag_q[3]),
		.prio_q    (prio_q[3]),
		.req_q     (req_q[3]),
		.new_req   (new_req[3])
	);

	assign src_irq_req = {req_q[3], req_q[2], req_q[1], req_q[0]}; // RULE11

	// ==================================================================
	// Event status, mask and interrupt line
	// A new request in the cycle of a clearing read is kept.
	assign status_clr = rd_pend_q && (addr_q == OFF_STATUS);

	always_comb begin
		status_d = (status_clr ? STATUS_RESET : status_q) | new_req;
		mask_d   = mask_q;
		if (wr_commit && (addr_q == OFF_MASK)) begin
			mask_d = hwdata[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= MASK_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	// The line is registered so that it never glitches as status settles.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_d & mask_d);
		end
	end

	// ==================================================================
	// Highest presented priority level
	// Equal levels need no tie break, since only the level leaves the block.
	always_comb begin
		level_d = PRIO_OFF;
		for (int b = 0; b < NUM_BANKS; b++) begin
			for (int s = 0; s < BANK_W; s++) begin
				if (req_q[b][s]
						&& (prio_q[b][s*PRIO_W +: PRIO_W] > level_d)) begin
					level_d = prio_q[b][s*PRIO_W +: PRIO_W]; // RULE10
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_q <= PRIO_OFF;
		end else begin
			level_q <= level_d;
		end
	end

	// ==================================================================
	// Outputs
	assign hreadyout = hready_q;
	assign hrdata    = hrdata_q;
	assign hresp     = HRESP_OKAY;
	assign irq       = irq_q;
	assign top_level = level_q;

endmodule : ieb_top

`default_nettype wire

// ---- pkg/ieb_pkg.sv ----
// Constants shared by the interrupt enable bank and its bus slave.
package ieb_pkg;

	// ==================================================================
	// Geometry
	localparam int NUM_BANKS    = 4;
	localparam int BANK_W       = 16;
	localparam int PRIO_W       = 3;
	localparam int PRIO_WORDS   = 4;
	localparam int FIELD_STRIDE = 4;
	localparam int FIELDS_WORD  = 4;
	localparam int NUM_SRC      = NUM_BANKS * BANK_W;

	// ==================================================================
	// Implemented bit positions of each enable and flag bank
	localparam logic [15:0] BANK0_IMPL = 16'h3FEF;
	localparam logic [15:0] BANK1_IMPL = 16'hFEDF;
	localparam logic [15:0] BANK2_IMPL = 16'h3FE3;
	localparam logic [15:0] BANK3_IMPL = 16'h4066;
	localparam logic [15:0] IMPL_MASK [NUM_BANKS] = '{
		BANK0_IMPL, BANK1_IMPL, BANK2_IMPL, BANK3_IMPL
	};

	// ==================================================================
	// Reset values
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [15:0] FLAG_RESET   = 16'h0000;
	localparam logic [2:0]  PRIO_RESET   = 3'h4;
	localparam logic [2:0]  PRIO_OFF     = 3'h0;
	localparam logic [3:0]  STATUS_RESET = 4'h0;
	localparam logic [3:0]  MASK_RESET   = 4'h0;

	// ==================================================================
	// Register byte offsets
	localparam logic [7:0] OFF_ENABLE_BASE = 8'h00;
	localparam logic [7:0] OFF_FLAG_BASE   = 8'h10;
	localparam logic [7:0] OFF_PRIO_BASE   = 8'h20;
	localparam logic [7:0] OFF_STATUS      = 8'h60;
	localparam logic [7:0] OFF_MASK        = 8'h64;
	localparam int         WORD_BYTES      = 4;
	localparam int         PRIO_BANK_BYTES = 16;

	// ==================================================================
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage : ieb_pkg

// ---- rtl/ieb_bank.sv ----
// One 16-source bank: enables, flags, priorities and request gating.
`timescale 1ns/1ns
`default_nettype none

module ieb_bank
	import ieb_pkg::*;
#(
	parameter logic [15:0] IMPL = 16'h0000
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        enable_we,
	input  wire logic        flag_we,
	input  wire logic [3:0]  prio_we,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] src_req,
	output logic      [15:0] enable_q,
	output logic      [15:0] flag_q,
	output logic      [47:0] prio_q,
	output logic      [15:0] req_q,
	output logic             new_req
);

	logic [15:0] req_d;
	logic [15:0] flag_d;

	// ==================================================================
	// Enable register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q <= ENABLE_RESET; // RULE3
		end else if (enable_we) begin
			enable_q <= wdata & IMPL; // RULE2 RULE3
		end
	end

	// ==================================================================
	// Flag register; a hardware request wins over a software write.
	always_comb begin
		flag_d = ((flag_we ? wdata : flag_q) | src_req) & IMPL; // RULE9
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= FLAG_RESET; // RULE9
		end else begin
			flag_q <= flag_d;
		end
	end

	// ==================================================================
	// Priority fields; an unimplemented source keeps a zero field.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int s = 0; s < BANK_W; s++) begin
				prio_q[s*PRIO_W +: PRIO_W] <=
					IMPL[s] ? PRIO_RESET : PRIO_OFF; // RULE2
			end
		end else begin
			for (int s = 0; s < BANK_W; s++) begin
				if (IMPL[s] && prio_we[s / FIELDS_WORD]) begin // RULE2
					prio_q[s*PRIO_W +: PRIO_W] <= // RULE10
						wdata[(s % FIELDS_WORD) * FIELD_STRIDE +: PRIO_W];
				end
			end
		end
	end

	always_comb begin
		for (int s = 0; s < BANK_W; s++) begin
			req_d[s] = flag_q[s] & enable_q[s] // RULE1 RULE11
				& (prio_q[s*PRIO_W +: PRIO_W] != PRIO_OFF); // RULE10
		end
	end

	// ==================================================================
	// Presented requests
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= 16'h0000;
		end else begin
			req_q <= req_d; // RULE11
		end
	end

	assign new_req = |(req_d & ~req_q);

endmodule : ieb_bank

`default_nettype wire

// ---- bench/ieb_chk.sv ----
// Port checker for the interrupt enable bank.
`timescale 1ns/1ns
`default_nettype none
module ieb_chk
	import ieb_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [63:0] src_irq_req,
	input wire logic [2:0]  top_level
);
	// =====
	// Bus and request relations
	logic [63:0] impl;
	logic        tk;
	assign impl = {BANK3_IMPL, BANK2_IMPL, BANK1_IMPL, BANK0_IMPL};
	assign tk = hsel && htrans[1] && hready;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_impl; (src_irq_req & ~impl) == 64'h0; endproperty
	a_impl: assert property (p_impl) else $error("stray request");
	property p_hi; hrdata[31:16] == 16'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper data set");
	property p_rst; $rose(hresetn) |-> src_irq_req == 64'h0; endproperty
	a_rst: assert property (p_rst) else $error("request at reset");
	property p_off; src_irq_req == 64'h0 |=> top_level == 3'h0; endproperty
	a_off: assert property (p_off) else $error("level without req");
	property p_on; src_irq_req != 64'h0 |=> top_level != 3'h0; endproperty
	a_on: assert property (p_on) else $error("zero level");
	property p_rd; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rd: assert property (p_rd) else $error("read timing");
	property p_wr; tk && hwrite |=> hreadyout; endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_hold; hreadyout |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule : ieb_chk
bind ieb_top ieb_chk ieb_chk_inst (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hrdata, .src_irq_req, .top_level);
`default_nettype wire

// ---- bench/ieb_src_model.sv ----
// Behavioural model of the peripheral sources that raise requests.
`timescale 1ns/1ns
`default_nettype none
module ieb_src_model (
	input  wire logic        hclk,
	input  wire logic        fire,
	input  wire logic [63:0] pat,
	output logic      [63:0] src_req
);
	// =====
	// Sources pulse once; external pins are taken as routed to a pin.
	always @(posedge hclk) src_req <= fire ? pat : 64'h0;
endmodule : ieb_src_model
`default_nettype wire

// ---- bench/interrupt_enable_bank_test.sv ----
// Self-checking bench for the interrupt enable bank.
`timescale 1ns/1ns
`default_nettype none
module interrupt_enable_bank_test
	import ieb_pkg::*;
;
	// =====
	// Signals
	logic        hclk = 0;
	logic        hresetn = 0;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic        fire = 0;
	logic        dp = 0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [63:0] pat = 64'h0;
	logic        hreadyout, hresp, irq;
	logic [31:0] hrdata;
	logic [63:0] src_req, src_irq_req, im;
	logic [2:0]  top_level;
	logic [31:0] q[$];
	int          failures = 0;
	int          samples_checked = 0;
	assign im = {BANK3_IMPL, BANK2_IMPL, BANK1_IMPL, BANK0_IMPL};
	ieb_top ieb_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
		.hresp, .src_req, .src_irq_req, .top_level, .irq);
	ieb_src_model ieb_src_model_inst (.hclk, .fire, .pat, .src_req);
	initial forever #20 hclk = ~hclk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			failures++;
			$display("unexpected %0t bus hang", $time);
			print_verdict();
		end
	endtask : wt
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic pulse(input logic [63:0] p);
		pat <= p;
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask : pulse
	// =====
	// Read data are compared when each read data phase completes.
	always @(posedge hclk) begin
		if (dp && hreadyout === 1'b1) begin
			chk({32'h0, hrdata}, {32'h0, q.pop_front()});
			chk({63'h0, hresp}, {63'h0, HRESP_OKAY});
		end
		if (hreadyout === 1'b1)
			dp <= hsel && htrans[1] && !hwrite;
	end
	initial begin
		logic [31:0] r;
		logic [7:0]  a;
		void'($urandom(32'h2ce7));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int b = 0; b < NUM_BANKS; b++) begin
			r = $urandom;
			a = OFF_ENABLE_BASE + 8'(4 * b);
			rd(a, 32'h0);
			rd(OFF_FLAG_BASE + 8'(4 * b), 32'h0);
			bus(1'b1, a, r);
			rd(a, {16'h0, r[15:0] & IMPL_MASK[b]});
			bus(1'b1, a, 32'hFFFFFFFF);
			rd(a, {16'h0, IMPL_MASK[b]});
		end
		rd(8'h80, 32'h0);
		rd(OFF_PRIO_BASE, 32'h4444);
		bus(1'b1, OFF_PRIO_BASE, 32'h4440);
		bus(1'b1, OFF_MASK, 32'h1);
		pulse(~64'h0);
		chk(src_irq_req, im & ~64'h1);
		chk({61'h0, top_level}, 64'h4);
		chk({63'h0, irq}, 64'h1);
		rd(OFF_FLAG_BASE, {16'h0, BANK0_IMPL});
		bus(1'b1, OFF_ENABLE_BASE + 8'h4, 32'h0);
		repeat (2) @(posedge hclk);
		chk(src_irq_req, im & ~64'h1 & ~(64'hFFFF << 16));
		rd(OFF_STATUS, 32'hF);
		repeat (3) @(posedge hclk);
		chk({63'h0, irq}, 64'h0);
		bus(1'b1, OFF_MASK, 32'h0);
		bus(1'b1, OFF_FLAG_BASE + 8'h8, 32'h0);
		pulse(im);
		chk({63'h0, irq}, 64'h0);
		bus(1'b1, OFF_MASK, 32'h4);
		repeat (2) @(posedge hclk);
		chk({63'h0, irq}, 64'h1);
		hresetn <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
		chk(src_irq_req, 64'h0);
		print_verdict();
	end
endmodule : interrupt_enable_bank_test
`default_nettype wire
